/* stlc_pkg.sv */
// Purpose: constants for the transmit lane level control block
// Assumes: one 32-bit level word per lane, four lanes
// Notes: bits above the stored fields read as zero
package stlc_pkg;
   localparam int NUM_LANES = 4;
   localparam int AW = 4;
   localparam int CODE_W = 21;
   // Register offsets
   localparam logic [AW-1:0] OFS_LEVEL_CTRL = 4'h0;
   localparam logic [AW-1:0] OFS_XCVR_CTRL = 4'h4;
   // Field positions in the level word
   localparam int G1_LVL_LSB = 0;
   localparam int G1_FDC_LSB = 5;
   localparam int G2M_LVL_LSB = 8;
   localparam int G2M_FDC_LSB = 13;
   localparam int G2S_LVL_LSB = 16;
   localparam int LVL_W = 5;
   localparam int FDC_W = 3;
   localparam int LSEL_W = 4;
   // Values after reset
   localparam logic [LVL_W-1:0] RST_G1_LVL = 5'h11;
   localparam logic [FDC_W-1:0] RST_G1_FDC = 3'h4;
   localparam logic [LVL_W-1:0] RST_G2M_LVL = 5'h17;
   localparam logic [FDC_W-1:0] RST_G2M_FDC = 3'h4;
   localparam logic [LVL_W-1:0] RST_G2S_LVL = 5'h13;
   localparam logic [CODE_W-1:0] RST_CODES =
      {RST_G2S_LVL, RST_G2M_FDC, RST_G2M_LVL, RST_G1_FDC, RST_G1_LVL};
   localparam logic [LSEL_W-1:0] RST_LSEL = 4'h1;
   localparam logic LOW_SWING_ON = 1'h1;
   typedef enum logic {STLC_DEEMPH_3P5, STLC_DEEMPH_6P0} stlc_deemph_t;
endpackage

/* stlc_store_if.sv */
// Purpose: carries lane writes into the code store and codes out
// Assumes: single clock domain
// Notes: codes are flip-flop outputs of the store
`timescale 1ns/10ps
interface stlc_store_if;
   logic [stlc_pkg::NUM_LANES-1:0] wr_mask;
   logic [stlc_pkg::CODE_W-1:0] wr_data;
   logic [stlc_pkg::CODE_W-1:0] codes [stlc_pkg::NUM_LANES];
   modport ctrl (output wr_mask, output wr_data, input codes);
   modport store (input wr_mask, input wr_data, output codes);
endinterface

/* stlc_store.sv */
// Purpose: per-lane storage of the transmit level and fine codes
// Assumes: write mask already decoded from the lane select
// Notes: lanes outside the mask keep their values
`timescale 1ns/10ps
module stlc_store (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic ce,
   stlc_store_if.store sif
);
   logic [stlc_pkg::CODE_W-1:0] code_ff [stlc_pkg::NUM_LANES];

   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < stlc_pkg::NUM_LANES; i++) begin
         if (!rstn) begin
            code_ff[i] <= stlc_pkg::RST_CODES;
         end else if (ce && sif.wr_mask[i]) begin
            code_ff[i] <= sif.wr_data; // [R8]
         end
      end
   end // [R9]

   always_comb begin
      for (int i = 0; i < stlc_pkg::NUM_LANES; i++) begin
         sif.codes[i] = code_ff[i];
      end
   end
endmodule // stlc_store

/* stlc_top.sv */
// Purpose: transmit lane level control register bank and code steering
// Assumes: rate, de-emphasis and swing inputs come from sys_clk logic
// Notes: read data valid the cycle after the read strobe only
// Functional notes
// [R1] Gen 1 full-swing level, bits 4:0, reset 0x11
// [R2] Gen 1 fine de-emphasis, bits 7:5, reset 0x4
// [R3] Software keeps Gen 1 de-emphasis near -3.5dB
// [R4] Gen 2 mild level, bits 12:8, reset 0x17
// [R5] Gen 2 mild fine code, bits 15:13, reset 0x4
// [R6] Gen 2 strong level, bits 20:16, reset 0x13
// [R7] Fine codes ignored in low-swing mode
// [R8] Writes reach only lanes picked by lane select
// [R9] Stored codes are sticky on every lane
// [R10] Level code is pre-de-emphasis swing
// [R11] Low-swing active when enable bit equals one
// [R12] Reads return codes of the selected lane
`timescale 1ns/10ps
module stlc_top (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [stlc_pkg::AW-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic [stlc_pkg::NUM_LANES-1:0] gen2_rate,
   input wire logic [stlc_pkg::NUM_LANES-1:0] deemphasis_select,
   input wire logic [stlc_pkg::NUM_LANES-1:0] low_swing_enable,
   output logic [stlc_pkg::NUM_LANES*stlc_pkg::LVL_W-1:0] drv_level,
   output logic [stlc_pkg::NUM_LANES*stlc_pkg::FDC_W-1:0] drv_fine,
   output logic [stlc_pkg::NUM_LANES-1:0] drv_fine_en,
   output logic [stlc_pkg::NUM_LANES-1:0] drv_full_swing
);
   localparam int NL = stlc_pkg::NUM_LANES;
   localparam int LW = stlc_pkg::LVL_W;
   localparam int FW = stlc_pkg::FDC_W;

   // Drive mode of a lane, picked from swing, rate and de-emphasis
   typedef enum {
      STLC_MODE_LOW,
      STLC_MODE_G1,
      STLC_MODE_G2M,
      STLC_MODE_G2S
   } stlc_mode_t;

   stlc_store_if sif ();

   logic [stlc_pkg::LSEL_W-1:0] lane_select_ff;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic [NL*LW-1:0] level_ff;
   logic [NL*LW-1:0] nxt_level;
   logic [NL*FW-1:0] fine_ff;
   logic [NL*FW-1:0] nxt_fine;
   logic [NL-1:0] fine_en_ff;
   logic [NL-1:0] nxt_fine_en;
   logic [NL-1:0] full_ff;
   logic [NL-1:0] nxt_full;
   logic lvl_wr;
   stlc_mode_t mode [NL];

   // Lowest selected lane answers reads; none selected reads zero
   function automatic logic [stlc_pkg::CODE_W-1:0] sel_codes(
      input logic [stlc_pkg::LSEL_W-1:0] sel,
      input logic [stlc_pkg::CODE_W-1:0] codes [NL]);
      logic [stlc_pkg::CODE_W-1:0] r;
      r = '0;
      for (int i = NL - 1; i >= 0; i--) begin
         if (sel[i]) begin
            r = codes[i];
         end
      end
      return r;
   endfunction

   // Lanes a level write reaches; an empty select reaches none
   function automatic logic [NL-1:0] lane_mask(
      input logic hit,
      input logic [stlc_pkg::LSEL_W-1:0] sel);
      logic [NL-1:0] m;
      m = '0;
      if (hit) begin
         m = sel;
      end
      return m;
   endfunction

   // Low swing overrides rate and de-emphasis select
   function automatic stlc_mode_t lane_mode(
      input logic low_swing,
      input logic gen2,
      input logic deemph);
      stlc_mode_t m;
      m = STLC_MODE_LOW;
      if (low_swing != stlc_pkg::LOW_SWING_ON) begin // [R11]
         if (!gen2) begin
            m = STLC_MODE_G1;
         end else if (deemph == stlc_pkg::STLC_DEEMPH_3P5) begin
            m = STLC_MODE_G2M;
         end else begin
            m = STLC_MODE_G2S;
         end
      end
      return m;
   endfunction

   function automatic logic [stlc_pkg::LVL_W-1:0] level_at(
      input logic [stlc_pkg::CODE_W-1:0] word,
      input int lsb);
      return word[lsb +: stlc_pkg::LVL_W];
   endfunction

   function automatic logic [stlc_pkg::FDC_W-1:0] fine_at(
      input logic [stlc_pkg::CODE_W-1:0] word,
      input int lsb);
      return word[lsb +: stlc_pkg::FDC_W];
   endfunction

   assign lvl_wr = wr && (addr == stlc_pkg::OFS_LEVEL_CTRL);
   assign sif.wr_mask = lane_mask(lvl_wr, lane_select_ff); // [R8]
   assign sif.wr_data = wdata[stlc_pkg::CODE_W-1:0]; // [R1] [R2] [R4] [R5] [R6]

   stlc_store u_store (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .ce(ce),
      .sif(sif)
   );

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         lane_select_ff <= stlc_pkg::RST_LSEL;
      end else if (ce && wr && addr == stlc_pkg::OFS_XCVR_CTRL) begin
         lane_select_ff <= wdata[stlc_pkg::LSEL_W-1:0];
      end
   end

   always_comb begin
      nxt_rdata = '0;
      if (addr == stlc_pkg::OFS_LEVEL_CTRL) begin
         nxt_rdata[stlc_pkg::CODE_W-1:0] =
            sel_codes(lane_select_ff, sif.codes); // [R12]
      end else if (addr == stlc_pkg::OFS_XCVR_CTRL) begin
         nxt_rdata[stlc_pkg::LSEL_W-1:0] = lane_select_ff;
      end
   end

   // Read data stand one enabled cycle only, zero otherwise; held while ce is low
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         rdata_ff <= '0;
      end else if (ce) begin
         rdata_ff <= rd ? nxt_rdata : '0;
      end
   end
   assign rdata = rdata_ff;

   // Modes follow the inputs every cycle
   always_comb begin
      for (int i = 0; i < NL; i++) begin
         mode[i] = lane_mode(low_swing_enable[i], gen2_rate[i],
                             deemphasis_select[i]);
      end
   end

   // Steer each lane's codes by its mode
   always_comb begin
      nxt_level = '0;
      nxt_fine = '0;
      nxt_fine_en = '0;
      nxt_full = '0;
      for (int i = 0; i < NL; i++) begin
         case (mode[i])
            STLC_MODE_G1: begin
               nxt_full[i] = 1'b1;
               nxt_fine_en[i] = 1'b1;
               nxt_level[i*LW +: LW] =
                  level_at(sif.codes[i], stlc_pkg::G1_LVL_LSB); // [R1] [R10]
               nxt_fine[i*FW +: FW] =
                  fine_at(sif.codes[i], stlc_pkg::G1_FDC_LSB); // [R2]
            end
            STLC_MODE_G2M: begin
               nxt_full[i] = 1'b1;
               nxt_fine_en[i] = 1'b1;
               nxt_level[i*LW +: LW] =
                  level_at(sif.codes[i], stlc_pkg::G2M_LVL_LSB); // [R4]
               nxt_fine[i*FW +: FW] =
                  fine_at(sif.codes[i], stlc_pkg::G2M_FDC_LSB); // [R5]
            end
            STLC_MODE_G2S: begin
               // No strong fine code is stored; fine code and fine enable stay zero here
               nxt_full[i] = 1'b1;
               nxt_level[i*LW +: LW] =
                  level_at(sif.codes[i], stlc_pkg::G2S_LVL_LSB); // [R6]
            end
            default: begin
               // Low swing: de-emphasis off, fine codes not presented
               nxt_level[i*LW +: LW] = '0;
               nxt_fine[i*FW +: FW] = '0; // [R7]
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         level_ff <= '0;
         fine_ff <= '0;
         fine_en_ff <= '0;
         full_ff <= '0;
      end else if (ce) begin
         level_ff <= nxt_level;
         fine_ff <= nxt_fine;
         fine_en_ff <= nxt_fine_en;
         full_ff <= nxt_full;
      end
   end

   assign drv_level = level_ff;
   assign drv_fine = fine_ff;
   assign drv_fine_en = fine_en_ff;
   assign drv_full_swing = full_ff;
endmodule // stlc_top

/* stlc_asserts.sv */
// Purpose: port checks for the lane level bank
// Assumes: lane inputs steady while ce is low
// Notes: lane 0 stands for all lanes
`timescale 1ns/10ps
module stlc_asserts (
   input logic sys_clk,
   input logic rstn,
   input logic [3:0] addr,
   input logic rd,
   input logic [31:0] rdata,
   input logic [3:0] gen2_rate,
   input logic [3:0] deemphasis_select,
   input logic [3:0] low_swing_enable,
   input logic [19:0] drv_level,
   input logic [11:0] drv_fine,
   input logic [3:0] drv_fine_en,
   input logic [3:0] drv_full_swing
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // Gated on past rstn: outputs lag one edge
   sequence s_full;
      $past(rstn) && !$past(low_swing_enable[0]);
   endsequence
   a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("rdata not idle");
   a_upper_zero: assert property ($past(rd) |-> rdata[31:21] == 11'h0)
      else $error("rdata upper bits set");
   a_reset_word: assert property (!$past(rstn) && rd && addr == 4'h0
      |=> rdata == 32'h139791) else $error("reset word wrong");
   a_low_off: assert property ($past(low_swing_enable[0]) |->
      drv_fine_en[0] == 1'b0 && drv_level[4:0] == 5'h0) else $error("low");
   a_full_on: assert property (s_full |-> drv_full_swing[0] == 1'b1)
      else $error("full swing off");
   a_g1_fine: assert property (s_full ##0 !$past(gen2_rate[0]) |->
      drv_fine_en[0] == 1'b1) else $error("gen1 fine off");
   a_g2m_fine: assert property (s_full ##0 $past(gen2_rate[0]) &&
      !$past(deemphasis_select[0]) |-> drv_fine_en[0] == 1'b1)
      else $error("gen2 fine off");
   a_g2s_nofine: assert property (s_full ##0 $past(gen2_rate[0]) &&
      $past(deemphasis_select[0]) |-> drv_fine[2:0] == 3'h0)
      else $error("gen2 strong fine set");
endmodule // stlc_asserts

/* testbench.sv */
// Purpose: self-checking bench for the lane level bank
// Assumes: lane select at offset 0x4
// Notes: ce dropped once, lane inputs steady, to check the freeze
`timescale 1ns/10ps
module testbench;
   logic sys_clk = 0, rstn = 0, wr = 0, rd = 0, ce = 1;
   logic [3:0] addr = 4'h0, g2 = 4'h0, de = 4'h0, ls = 4'h0, sel;
   logic [31:0] wdata = 32'h0, rdata, d, e;
   logic [19:0] drv_level;
   logic [11:0] drv_fine;
   logic [3:0] drv_fine_en, drv_full_swing;
   logic [20:0] m [4];
   logic [39:0] x;
   int seed = 17, error_cnt = 0, tests_run = 0;
   always #5 sys_clk = ~sys_clk;
   stlc_top dut (.sys_clk, .rstn, .ce, .addr, .wdata, .wr, .rd,
      .rdata, .gen2_rate(g2), .deemphasis_select(de),
      .low_swing_enable(ls), .drv_level, .drv_fine, .drv_fine_en,
      .drv_full_swing);
   task chk(input logic [39:0] g, input logic [39:0] v);
      tests_run++;
      if (g !== v) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, v);
      end
   endtask
   task wrt(input logic [3:0] a, input logic [31:0] v);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      rd <= 1'b0;
      @(posedge sys_clk);
   endtask
   // Sample mid-cycle: rdata stands one cycle only
   task rdx(input logic [3:0] a, input logic [31:0] v);
      addr <= a;
      rd <= 1'b1;
      wr <= 1'b0;
      @(posedge sys_clk);
      rd <= 1'b0;
      @(negedge sys_clk);
      chk({8'h0, rdata}, {8'h0, v});
      @(posedge sys_clk);
   endtask
   task close_out();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      for (int i = 0; i < 4; i++) m[i] = 21'h139791;
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      rdx(4'h0, 32'h139791);
      rdx(4'h4, 32'h1);
      $display("reset test done");
      repeat (60) begin
         d = $random(seed);
         sel = d[3:0];
         {ls, de, g2} <= d[15:4];
         wrt(4'h4, d);
         d = $random(seed);
         wrt(4'h8, ~d);
         wrt(4'h0, d);
         e = 32'h0;
         for (int i = 3; i >= 0; i--) if (sel[i]) begin
            m[i] = d[20:0];
            e = {11'h0, d[20:0]};
         end
         rdx(4'h0, e);
         rdx(4'h4, {28'h0, sel});
         rdx(4'h8, 32'h0);
         x = 40'h0;
         for (int i = 0; i < 4; i++) if (!ls[i]) begin
            x[36+i] = 1'b1;
            x[32+i] = !(g2[i] && de[i]);
            x[5*i+:5] = !g2[i] ? m[i][4:0] : de[i] ? m[i][20:16] : m[i][12:8];
            x[20+3*i+:3] = !g2[i] ? m[i][7:5] : de[i] ? 3'h0 : m[i][15:13];
         end
         @(negedge sys_clk);
         chk({drv_full_swing, drv_fine_en, drv_fine, drv_level}, x);
         @(posedge sys_clk);
      end
      $display("random test done");
      // Strobes under ce low must change nothing, rdata included
      wrt(4'h4, 32'hF);
      ce <= 1'b0;
      wrt(4'h0, {11'h0, ~m[0]});
      wrt(4'h4, 32'h0);
      rdx(4'h0, 32'h0);
      ce <= 1'b1;
      rdx(4'h4, 32'hF);
      rdx(4'h0, {11'h0, m[0]});
      wrt(4'h0, 32'h139791);
      for (int i = 0; i < 4; i++) m[i] = 21'h139791;
      rdx(4'h0, 32'h139791);
      $display("freeze test done");
      close_out();
   end
endmodule // testbench
bind stlc_top stlc_asserts u_chk (.*);
